// ===== design/lgb_cfg.svh
// Offsets, field positions, reset values and counts of the logic cell block.
`ifndef LGB_CFG_SVH
`define LGB_CFG_SVH

// Register byte offsets on the plain register port.
`define LGB_ADDR_CELL_SEL 8'h00
`define LGB_ADDR_TAB_SEL  8'h04
`define LGB_ADDR_IN_IDX   8'h08
`define LGB_ADDR_IN_SRC   8'h0C
`define LGB_ADDR_IN_ACT   8'h10
`define LGB_ADDR_ROW_IDX  8'h14
`define LGB_ADDR_ROW_BIT  8'h18
`define LGB_ADDR_TAB_WORD 8'h1C
`define LGB_ADDR_STATUS   8'h20

// Widths and counts.
`define LGB_ADDR_W    8
`define LGB_DATA_W    32
`define LGB_SRC_W     5
`define LGB_ACT_W     3
`define LGB_SRC_COUNT 19
`define LGB_ACT_COUNT 5
`define LGB_IN_COUNT  3
`define LGB_ROWS      8
`define LGB_LINES     4

// Reset values of the configuration fields.
`define LGB_RST_SRC   5'h00
`define LGB_RST_ACT   3'h1
`define LGB_RST_TABLE 8'h00

// Status register field positions.
`define LGB_STAT_CELL0 0
`define LGB_STAT_CELL1 1

`endif

// ===== design/lgb_pkg.sv
// Types shared by the logic cell block and its cells.
`include "lgb_cfg.svh"
package lgb_pkg;

   // Internal signal that an input of a cell may follow.
   typedef enum logic [`LGB_SRC_W-1:0] {
      LGB_SRC_ZERO, LGB_SRC_LINE0, LGB_SRC_LINE1, LGB_SRC_LINE2, LGB_SRC_LINE3,
      LGB_SRC_USER0, LGB_SRC_USER1, LGB_SRC_USER2, LGB_SRC_USER3,
      LGB_SRC_CTR0_START, LGB_SRC_CTR1_START, LGB_SRC_CTR0_END, LGB_SRC_CTR1_END,
      LGB_SRC_CELL0, LGB_SRC_CELL1, LGB_SRC_EXP_START, LGB_SRC_EXP_END,
      LGB_SRC_FRAME_WAIT, LGB_SRC_ACQ_ACTIVE
   } lgb_src_e;

   // How the chosen signal counts as asserted.
   typedef enum logic [`LGB_ACT_W-1:0] {
      LGB_ACT_LOW, LGB_ACT_HIGH, LGB_ACT_FALL, LGB_ACT_RISE, LGB_ACT_ANY
   } lgb_act_e;

   // Which truth table software is configuring.
   typedef enum logic {LGB_TAB_VALUE, LGB_TAB_ENABLE} lgb_tab_e;

   typedef struct packed {
      lgb_src_e src;
      lgb_act_e act;
   } lgb_inp_s;

   // One cell: three shared inputs and the two truth tables.
   typedef struct packed {
      lgb_inp_s [`LGB_IN_COUNT-1:0] inp;
      logic [`LGB_ROWS-1:0]         valTab;
      logic [`LGB_ROWS-1:0]         enTab;
   } lgb_cellcfg_s;

   // Register port request.
   typedef struct packed {
      logic [`LGB_ADDR_W-1:0] addr;
      logic [`LGB_DATA_W-1:0] wdata;
      logic                   wr;
      logic                   rd;
   } lgb_bus_s;

   typedef struct packed {
      logic [`LGB_SRC_COUNT-1:0] prevSrc;
      logic                      out;
   } lgb_cell_state_s;

   typedef struct packed {
      lgb_cellcfg_s [1:0]     cfg;
      logic                   cellSel;
      lgb_tab_e               tabSel;
      logic [1:0]             inIdx;
      logic [2:0]             rowIdx;
      logic [`LGB_LINES-1:0]  lineMeta;
      logic [`LGB_LINES-1:0]  lineSync;
      logic [`LGB_DATA_W-1:0] rdData;
   } lgb_top_state_s;

endpackage : lgb_pkg

// ===== design/lgb_cell.sv
// One logic cell: input activation, value and enable tables, output flip-flop.
`timescale 1ns/1ps
`default_nettype none
`include "lgb_cfg.svh"
module lgb_cell (
   // Clock, reset and enable.
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   // Configuration and candidate signals.
   input  wire lgb_pkg::lgb_cellcfg_s     cfg,
   input  wire logic [`LGB_SRC_COUNT-1:0] srcVec,
   // Cell result.
   output logic                           cellOut
);

   lgb_pkg::lgb_cell_state_s r;
   lgb_pkg::lgb_cell_state_s n;
   logic [2:0]               hit;
   logic [2:0]               row;
   logic                     valBit;
   logic                     enBit;

   // Decides whether one input counts as asserted this cycle.
   function automatic logic actHit(lgb_pkg::lgb_act_e a, logic cur, logic prv);
      logic h;
      h = 1'b0;
      unique case (a)
         lgb_pkg::LGB_ACT_LOW:  h = ~cur;
         lgb_pkg::LGB_ACT_HIGH: h = cur;
         lgb_pkg::LGB_ACT_FALL: h = prv & ~cur;
         lgb_pkg::LGB_ACT_RISE: h = ~prv & cur;
         lgb_pkg::LGB_ACT_ANY:  h = prv ^ cur;
         default:               h = 1'b0;
      endcase
      return h;
   endfunction : actHit

   // Edges compare against the sample of the previous enabled cycle, so an
   // edge yields exactly one asserted cycle while levels follow directly.
   always_comb begin
      for (int i = 0; i < `LGB_IN_COUNT; i++) begin
         hit[i] = actHit(cfg.inp[i].act, srcVec[cfg.inp[i].src],
                         r.prevSrc[cfg.inp[i].src]);
      end
      row    = {hit[2], hit[1], hit[0]};
      valBit = cfg.valTab[row];
      enBit  = cfg.enTab[row];
   end

   // The flip-flop loads the value table only while the enable table is true.
   always_comb begin
      n         = r;
      n.prevSrc = srcVec;
      n.out     = enBit ? valBit : r.out;
   end

   // State register; a low clock enable freezes it.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

   assign cellOut = r.out;

   property p_hold;
      @(posedge core_clk) disable iff (rst)
      ce && !enBit |=> cellOut == $past(cellOut);
   endproperty
   a_hold: assert property (p_hold) else $error("cell output moved while disabled");

   property p_load;
      @(posedge core_clk) disable iff (rst)
      ce && enBit |=> cellOut == $past(valBit);
   endproperty
   a_load: assert property (p_load) else $error("cell output missed value");

   property p_bypass;
      @(posedge core_clk) disable iff (rst)
      ce && cfg.enTab == 8'hFF |=> cellOut == $past(valBit);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass did not pass value");

   property p_edge_pulse;
      @(posedge core_clk) disable iff (rst)
      (ce && hit[0] && (cfg.inp[0].act == lgb_pkg::LGB_ACT_RISE ||
       cfg.inp[0].act == lgb_pkg::LGB_ACT_FALL)) ##1
      (ce && $stable(cfg.inp[0])) |-> !hit[0];
   endproperty
   a_edge_pulse: assert property (p_edge_pulse) else $error("edge held past one cycle");

endmodule : lgb_cell
`default_nettype wire

// ===== design/lgb_top.sv
// Logic cell block: two programmable cells behind a plain register port.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lgb_cfg.svh"
module lgb_top (
   // Clock, reset and enable.
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   // Register port.
   input  wire lgb_pkg::lgb_bus_s         bus,
   output logic [`LGB_DATA_W-1:0]         rdData,
   // I/O lines from the pins, not yet synchronised.
   input  wire logic [`LGB_LINES-1:0]     lineIn,
   // Internal event and state signals on core_clk.
   input  wire logic [3:0]                userOut,
   input  wire logic [1:0]                counterStart,
   input  wire logic [1:0]                counterEnd,
   input  wire logic                      exposureStart,
   input  wire logic                      exposureEnd,
   input  wire logic                      frameTriggerWait,
   input  wire logic                      acquisitionActive,
   // Cell results for other internal functions.
   output logic                           cellZeroOutput,
   output logic                           cellOneOutput
);

   lgb_pkg::lgb_top_state_s r;
   lgb_pkg::lgb_top_state_s n;
   lgb_pkg::lgb_cellcfg_s   curCell;
   lgb_pkg::lgb_inp_s       curInp;
   logic [`LGB_ROWS-1:0]    curTab;
   logic [1:0]              cellOuts;
   logic [`LGB_SRC_COUNT-1:0] srcVec;
   logic [`LGB_DATA_W-1:0]  rdVal;
   logic                    inIdxOk;
   logic                    srcOk;
   logic                    actOk;

   // Returns the table that the table selector points at.
   function automatic logic [`LGB_ROWS-1:0] pickTab(lgb_pkg::lgb_cellcfg_s c,
                                                   lgb_pkg::lgb_tab_e t);
      return (t == lgb_pkg::LGB_TAB_ENABLE) ? c.enTab : c.valTab;
   endfunction : pickTab

   // Reset image of all state, built from the configured reset values.
   function automatic lgb_pkg::lgb_top_state_s rstState();
      lgb_pkg::lgb_top_state_s s;
      s = '0;
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < `LGB_IN_COUNT; i++) begin
            s.cfg[c].inp[i].src = lgb_pkg::lgb_src_e'(`LGB_RST_SRC);
            s.cfg[c].inp[i].act = lgb_pkg::lgb_act_e'(`LGB_RST_ACT);
         end
         s.cfg[c].valTab = `LGB_RST_TABLE;
         s.cfg[c].enTab  = `LGB_RST_TABLE;
      end
      return s;
   endfunction : rstState

   // Zero-extends a narrow field to a read word.
   function automatic logic [`LGB_DATA_W-1:0] zext8(logic [7:0] v);
      return {24'h00_0000, v};
   endfunction : zext8

   // Candidate signals in source-code order; the lines come from the second
   // synchroniser stage, the rest are already on core_clk.
   always_comb begin
      srcVec = {acquisitionActive, frameTriggerWait, exposureEnd, exposureStart,
                cellOuts, counterEnd, counterStart, userOut, r.lineSync,
                1'b0};
   end

   // Views of the item that the selectors currently address.
   always_comb begin
      curCell = r.cfg[r.cellSel];
      inIdxOk = (r.inIdx < 2'(`LGB_IN_COUNT));
      curInp  = inIdxOk ? curCell.inp[r.inIdx] : '0;
      curTab  = pickTab(curCell, r.tabSel);
   end

   // Out-of-range source or activation codes are ignored rather than stored,
   // so a cell can never hold a code that decodes to nothing.
   always_comb begin
      srcOk = (bus.wdata[`LGB_SRC_W-1:0] < 5'(`LGB_SRC_COUNT));
      actOk = (bus.wdata[`LGB_ACT_W-1:0] < 3'(`LGB_ACT_COUNT));
   end

   // Read multiplexer; unmapped offsets and reserved bits read as zero.
   always_comb begin
      rdVal = '0;
      case (bus.addr)
         `LGB_ADDR_CELL_SEL: rdVal = zext8({7'h00, r.cellSel});
         `LGB_ADDR_TAB_SEL:  rdVal = zext8({7'h00, r.tabSel});
         `LGB_ADDR_IN_IDX:   rdVal = zext8({6'h00, r.inIdx});
         `LGB_ADDR_IN_SRC:   rdVal = zext8({3'h0, curInp.src});
         `LGB_ADDR_IN_ACT:   rdVal = zext8({5'h00, curInp.act});
         `LGB_ADDR_ROW_IDX:  rdVal = zext8({5'h00, r.rowIdx});
         `LGB_ADDR_ROW_BIT:  rdVal = zext8({7'h00, curTab[r.rowIdx]});
         `LGB_ADDR_TAB_WORD: rdVal = zext8(curTab);
         `LGB_ADDR_STATUS:   rdVal = zext8({6'h00, cellOuts});
         default:            rdVal = '0;
      endcase
   end

   // Next-state logic: synchroniser, read data register and register writes.
   always_comb begin
      n          = r;
      n.lineMeta = lineIn;
      n.lineSync = r.lineMeta;
      n.rdData   = bus.rd ? rdVal : '0;
      if (bus.wr) begin
         case (bus.addr)
            `LGB_ADDR_CELL_SEL: n.cellSel = bus.wdata[0];
            `LGB_ADDR_TAB_SEL:  n.tabSel  = lgb_pkg::lgb_tab_e'(bus.wdata[0]);
            `LGB_ADDR_IN_IDX:   n.inIdx   = bus.wdata[1:0];
            `LGB_ADDR_IN_SRC: begin
               // One storage place serves both tables of the cell.
               if (inIdxOk && srcOk) begin
                  n.cfg[r.cellSel].inp[r.inIdx].src =
                     lgb_pkg::lgb_src_e'(bus.wdata[`LGB_SRC_W-1:0]);
               end
            end
            `LGB_ADDR_IN_ACT: begin
               if (inIdxOk && actOk) begin
                  n.cfg[r.cellSel].inp[r.inIdx].act =
                     lgb_pkg::lgb_act_e'(bus.wdata[`LGB_ACT_W-1:0]);
               end
            end
            `LGB_ADDR_ROW_IDX:  n.rowIdx = bus.wdata[2:0];
            `LGB_ADDR_ROW_BIT: begin
               if (r.tabSel == lgb_pkg::LGB_TAB_ENABLE) begin
                  n.cfg[r.cellSel].enTab[r.rowIdx] = bus.wdata[0];
               end else begin
                  n.cfg[r.cellSel].valTab[r.rowIdx] = bus.wdata[0];
               end
            end
            `LGB_ADDR_TAB_WORD: begin
               if (r.tabSel == lgb_pkg::LGB_TAB_ENABLE) begin
                  n.cfg[r.cellSel].enTab = bus.wdata[7:0];
               end else begin
                  n.cfg[r.cellSel].valTab = bus.wdata[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   // State register; a low clock enable freezes everything, the bus included.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         r <= rstState();
      end else if (ce) begin
         r <= n;
      end
   end

   assign rdData = r.rdData;

   // The two cells; each sees the other's output as a source.
   for (genvar g = 0; g < 2; g++) begin : gCell
      lgb_cell uCell (
         .core_clk (core_clk),
         .rst      (rst),
         .ce       (ce),
         .cfg      (r.cfg[g]),
         .srcVec   (srcVec),
         .cellOut  (cellOuts[g])
      );
   end

   assign cellZeroOutput = cellOuts[0];
   assign cellOneOutput  = cellOuts[1];

   property p_word_write;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_TAB_WORD
      |=> curTab == $past(bus.wdata[7:0]);
   endproperty
   a_word_write: assert property (p_word_write) else $error("table word not loaded");

   property p_row_write;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_ROW_BIT
      |=> curTab[r.rowIdx] == $past(bus.wdata[0]) &&
          curTab == (($past(curTab) & ~(8'h01 << r.rowIdx)) |
                     (8'($past(bus.wdata[0])) << r.rowIdx));
   endproperty
   a_row_write: assert property (p_row_write) else $error("row bit not written");

   property p_shared_input;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_IN_SRC && inIdxOk && srcOk
      ##1 ce && bus.wr && bus.addr == `LGB_ADDR_TAB_SEL
      |=> curInp.src == $past(bus.wdata[`LGB_SRC_W-1:0], 2);
   endproperty
   a_shared_input: assert property (p_shared_input) else $error("input not shared");

   property p_status_read;
      @(posedge core_clk) disable iff (rst)
      ce && bus.rd && bus.addr == `LGB_ADDR_STATUS
      |=> rdData == {30'h0000_0000, $past(cellOuts)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   // Guards on writes, read-back and routing; refused codes must leave no trace.
   property p_bad_src;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_IN_SRC && !srcOk
      |=> $stable(curInp);
   endproperty
   a_bad_src: assert property (p_bad_src) else $error("bad source stored");

   property p_bad_act;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_IN_ACT && !actOk
      |=> $stable(curInp);
   endproperty
   a_bad_act: assert property (p_bad_act) else $error("bad activation stored");

   property p_sel_keep;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_TAB_SEL
      |=> $stable(curInp);
   endproperty
   a_sel_keep: assert property (p_sel_keep) else $error("table switch moved input");

   property p_cell_pick;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_CELL_SEL
      |=> r.cellSel == $past(bus.wdata[0]);
   endproperty
   a_cell_pick: assert property (p_cell_pick) else $error("cell select lost");

   // A line reaches the cells only through both synchroniser stages.
   property p_line_sync;
      @(posedge core_clk) disable iff (rst)
      ce ##1 ce
      |=> r.lineSync == $past(lineIn, 2);
   endproperty
   a_line_sync: assert property (p_line_sync) else $error("line sync wrong");

   property p_row_pick;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_ROW_IDX
      |=> r.rowIdx == $past(bus.wdata[2:0]);
   endproperty
   a_row_pick: assert property (p_row_pick) else $error("row index lost");

   property p_src_write;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_IN_SRC && inIdxOk && srcOk
      |=> curInp.src == $past(bus.wdata[`LGB_SRC_W-1:0]);
   endproperty
   a_src_write: assert property (p_src_write) else $error("source not stored");

   property p_idx3_read;
      @(posedge core_clk) disable iff (rst)
      ce && bus.rd && bus.addr == `LGB_ADDR_IN_SRC && r.inIdx == 2'h3
      |=> rdData == 32'h0000_0000;
   endproperty
   a_idx3_read: assert property (p_idx3_read) else $error("input 3 read nonzero");

   // A table write in one cell must never reach the other cell.
   property p_other_cell;
      @(posedge core_clk) disable iff (rst)
      ce && bus.wr && bus.addr == `LGB_ADDR_TAB_WORD
      |=> $stable(r.cfg[~r.cellSel]);
   endproperty
   a_other_cell: assert property (p_other_cell) else $error("other cell changed");

   property p_word_read;
      @(posedge core_clk) disable iff (rst)
      ce && bus.rd && bus.addr == `LGB_ADDR_TAB_WORD
      |=> rdData == {24'h00_0000, $past(curTab)};
   endproperty
   a_word_read: assert property (p_word_read) else $error("table word read wrong");

   property p_bit_read;
      @(posedge core_clk) disable iff (rst)
      ce && bus.rd && bus.addr == `LGB_ADDR_ROW_BIT
      |=> rdData == 32'($past(curTab[r.rowIdx]));
   endproperty
   a_bit_read: assert property (p_bit_read) else $error("row bit read wrong");

   property p_src_read;
      @(posedge core_clk) disable iff (rst)
      ce && bus.rd && bus.addr == `LGB_ADDR_IN_SRC && inIdxOk
      |=> rdData == 32'($past(curInp.src));
   endproperty
   a_src_read: assert property (p_src_read) else $error("source read wrong");

endmodule : lgb_top
`default_nettype wire

// ===== test/test_lgb_top.sv
// Self-checking testbench of the logic cell block.
`timescale 1ns/1ps
`default_nettype none
`include "lgb_cfg.svh"
module test_lgb_top;
   logic                    core_clk;
   logic                    rst;
   logic                    ce;
   lgb_pkg::lgb_bus_s       bus;
   logic [`LGB_DATA_W-1:0]  rdData;
   logic [15:0]             srcs;
   logic                    cellZeroOutput;
   logic                    cellOneOutput;
   int                      n_mismatch;
   int                      checks;

   // All candidate sources but zero and the two cell outputs in one vector, so a loop can pulse any of them.
   lgb_top dut (
      .core_clk          (core_clk),
      .rst               (rst),
      .ce                (ce),
      .bus               (bus),
      .rdData            (rdData),
      .lineIn            (srcs[3:0]),
      .userOut           (srcs[7:4]),
      .counterStart      (srcs[9:8]),
      .counterEnd        (srcs[11:10]),
      .exposureStart     (srcs[12]),
      .exposureEnd       (srcs[13]),
      .frameTriggerWait  (srcs[14]),
      .acquisitionActive (srcs[15]),
      .cellZeroOutput    (cellZeroOutput),
      .cellOneOutput     (cellOneOutput)
   );

   // Free-running 50 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus <= '0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so look there.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus <= '0;
      #1;
      chk(rdData, exp);
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc

   function automatic logic act_f(input int a, input logic p, input logic s);
      case (a)
         0: return !s;
         1: return s;
         2: return p & !s;
         3: return !p & s;
         default: return p ^ s;
      endcase
   endfunction : act_f

   task automatic t_reset();
      rd(`LGB_ADDR_IN_SRC, 32'h0000_0000);
      rd(`LGB_ADDR_IN_ACT, 32'h0000_0001);
      rd(`LGB_ADDR_TAB_WORD, 32'h0000_0000);
      rd(`LGB_ADDR_STATUS, 32'h0000_0000);
      rd(8'h24, 32'h0000_0000);
   endtask : t_reset

   task automatic t_tables();
      wr(`LGB_ADDR_TAB_WORD, 32'h0000_00C0);
      rd(`LGB_ADDR_TAB_WORD, 32'h0000_00C0);
      // The read word stands one cycle only, then the port reads zero.
      cyc(1);
      chk(rdData, 32'h0000_0000);
      wr(`LGB_ADDR_ROW_IDX, 32'h0000_0000);
      wr(`LGB_ADDR_ROW_BIT, 32'h0000_0001);
      rd(`LGB_ADDR_TAB_WORD, 32'h0000_00C1);
      wr(`LGB_ADDR_ROW_IDX, 32'h0000_0007);
      rd(`LGB_ADDR_ROW_BIT, 32'h0000_0001);
      wr(`LGB_ADDR_ROW_BIT, 32'h0000_0000);
      rd(`LGB_ADDR_TAB_WORD, 32'h0000_0041);
      wr(`LGB_ADDR_TAB_SEL, 32'h0000_0001);
      rd(`LGB_ADDR_TAB_WORD, 32'h0000_0000);
   endtask : t_tables

   // Inputs are shared by both tables; bad codes, index 3 and ce low are lost.
   task automatic t_inputs();
      wr(`LGB_ADDR_IN_SRC, 32'h0000_0005);
      wr(`LGB_ADDR_TAB_SEL, 32'h0000_0000);
      rd(`LGB_ADDR_IN_SRC, 32'h0000_0005);
      // Back-to-back strobes: source write, table switch and read with no gap.
      @(posedge core_clk);
      bus <= '{addr: `LGB_ADDR_IN_SRC, wdata: 32'h0000_0007, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus <= '{addr: `LGB_ADDR_TAB_SEL, wdata: 32'h0000_0001, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus <= '{addr: `LGB_ADDR_IN_SRC, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus <= '0;
      #1;
      chk(rdData, 32'h0000_0007);
      wr(`LGB_ADDR_IN_SRC, 32'h0000_0005);
      wr(`LGB_ADDR_TAB_SEL, 32'h0000_0000);
      wr(`LGB_ADDR_IN_SRC, 32'h0000_0013);
      wr(`LGB_ADDR_IN_ACT, 32'h0000_0005);
      rd(`LGB_ADDR_IN_SRC, 32'h0000_0005);
      rd(`LGB_ADDR_IN_ACT, 32'h0000_0001);
      wr(`LGB_ADDR_IN_IDX, 32'h0000_0003);
      wr(`LGB_ADDR_IN_SRC, 32'h0000_0006);
      rd(`LGB_ADDR_IN_SRC, 32'h0000_0000);
      wr(`LGB_ADDR_IN_IDX, 32'h0000_0001);
      @(posedge core_clk);
      ce <= 1'b0;
      bus <= '{addr: `LGB_ADDR_IN_SRC, wdata: 32'h0000_0006, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus <= '0;
      ce <= 1'b1;
      rd(`LGB_ADDR_IN_SRC, 32'h0000_0000);
      wr(`LGB_ADDR_IN_IDX, 32'h0000_0000);
      wr(`LGB_ADDR_CELL_SEL, 32'h0000_0001);
      rd(`LGB_ADDR_IN_SRC, 32'h0000_0000);
      wr(`LGB_ADDR_CELL_SEL, 32'h0000_0000);
   endtask : t_inputs

   // Bypassed cell 0 follows input 0 through each activation mode.
   task automatic t_activation();
      logic [4:0] pat;
      logic       prev;
      pat = 5'b00110;
      wr(`LGB_ADDR_TAB_SEL, 32'h0000_0001);
      wr(`LGB_ADDR_TAB_WORD, 32'h0000_00FF);
      wr(`LGB_ADDR_TAB_SEL, 32'h0000_0000);
      wr(`LGB_ADDR_TAB_WORD, 32'h0000_00AA);
      for (int a = 0; a < 5; a++) begin
         wr(`LGB_ADDR_IN_ACT, 32'(a));
         cyc(3);
         prev = 1'b0;
         for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            srcs[4] <= pat[i];
            cyc(1);
            chk(cellZeroOutput, act_f(a, prev, pat[i]));
            prev = pat[i];
         end
      end
      wr(`LGB_ADDR_IN_ACT, 32'h0000_0001);
   endtask : t_activation

   // Enable follows input 1: output holds while it is low.
   task automatic t_latch();
      wr(`LGB_ADDR_IN_IDX, 32'h0000_0001);
      wr(`LGB_ADDR_IN_SRC, 32'h0000_0006);
      wr(`LGB_ADDR_TAB_SEL, 32'h0000_0001);
      wr(`LGB_ADDR_TAB_WORD, 32'h0000_00CC);
      @(posedge core_clk);
      srcs[5:4] <= 2'b11;
      cyc(2);
      chk(cellZeroOutput, 1'b1);
      @(posedge core_clk);
      srcs[5:4] <= 2'b00;
      cyc(2);
      chk(cellZeroOutput, 1'b1);
      rd(`LGB_ADDR_STATUS, 32'h0000_0001);
      @(posedge core_clk);
      srcs[5:4] <= 2'b10;
      cyc(2);
      chk(cellZeroOutput, 1'b0);
      @(posedge core_clk);
      srcs <= '0;
      wr(`LGB_ADDR_TAB_WORD, 32'h0000_00FF);
      wr(`LGB_ADDR_IN_SRC, 32'h0000_0000);
      wr(`LGB_ADDR_IN_IDX, 32'h0000_0000);
   endtask : t_latch

   // Cell 1 input 0 walks codes 1 to 18 but 14, its own output; code 13 reaches cell 0 via user output 0.
   task automatic t_sources();
      wr(`LGB_ADDR_CELL_SEL, 32'h0000_0001);
      wr(`LGB_ADDR_TAB_WORD, 32'h0000_00FF);
      wr(`LGB_ADDR_TAB_SEL, 32'h0000_0000);
      wr(`LGB_ADDR_TAB_WORD, 32'h0000_00AA);
      for (int c = 1; c < 19; c++) begin
         if (c != 14) begin
            wr(`LGB_ADDR_IN_SRC, 32'(c));
            @(posedge core_clk);
            srcs <= 16'h0001 << ((c < 13) ? c - 1 : (c == 13) ? 4 : c - 3);
            cyc(4);
            chk(cellOneOutput, 1'b1);
            if (c == 13) begin
               rd(`LGB_ADDR_STATUS, 32'h0000_0003);
            end
            @(posedge core_clk);
            srcs <= '0;
            cyc(4);
            chk(cellOneOutput, 1'b0);
         end
      end
   endtask : t_sources

   // Watchdog sized well above the length of the whole sequence.
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      end_sim();
   end

   initial begin
      n_mismatch = 0;
      checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      bus = '0;
      srcs = '0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_tables();
      t_inputs();
      t_activation();
      t_latch();
      t_sources();
      end_sim();
   end
endmodule : test_lgb_top
`default_nettype wire
